// [psrp_pkg.sv]
// constants shared by the paged serial register port
package psrp_pkg;
    localparam int         ADDR_W         = 7;        // register address bits in the command byte
    localparam int         PAGE_W         = 4;        // page bits that reach the banked window
    localparam int         BYTE_W         = 8;        // one serial byte
    localparam int         MAX_BYTES      = 4;        // widest multi-byte register
    localparam int         IDX_W          = 2;        // byte index within a multi-byte register
    localparam int         CMD_RD_BIT     = 7;        // command bit: 1 read, 0 write
    localparam logic [6:0] PAGE_SEL_ADDR  = 7'h64;    // page_select register offset
    localparam logic [6:0] DIRECT_LAST    = 7'h64;    // highest address reachable on any page
    localparam logic [7:0] PAGE_SEL_RESET = 8'h00;    // page_select after reset
    localparam logic [3:0] CNT_CMD_DONE   = 4'h8;     // bits received when command byte is whole
    localparam logic [3:0] CNT_LAST_BIT   = 4'hf;     // count before the last data bit arrives

    // transfer phase, one-hot
    typedef enum logic [2:0] {
        PH_IDLE = 3'b001,
        PH_CMD  = 3'b010,
        PH_DATA = 3'b100
    } psrp_phase_type;

    // shift one serial bit into a byte in the chosen order
    function automatic logic [7:0] psrp_shift_in(input logic [7:0] cur, input logic bitIn, input logic lsbFirst);
        psrp_shift_in = lsbFirst ? {bitIn, cur[7:1]} : {cur[6:0], bitIn};
    endfunction : psrp_shift_in
endpackage : psrp_pkg

// [psrp_sync.sv]
// two-flop synchroniser for pin inputs
`timescale 1ns/1ps
module psrp_sync #(
    parameter int W = 1
) (
    input  wire logic         clk,
    input  wire logic         arst_n,
    input  wire logic         ce,
    input  wire logic [W-1:0] pinIn,
    output logic      [W-1:0] syncOut
);
    logic [W-1:0] stage1_reg;

    // first stage feeds only the second one
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            stage1_reg <= '0;
            syncOut    <= '0;
        end else if (ce) begin
            stage1_reg <= pinIn;
            syncOut    <= stage1_reg;
        end
    end
endmodule : psrp_sync

// [psrp_port.sv]
// serial slave port with paged addressing, write staging and read snapshot
`timescale 1ns/1ps
module psrp_port
    import psrp_pkg::*;
#(
    parameter int NBYTES = MAX_BYTES
) (
    input  wire logic                        clk,
    input  wire logic                        arst_n,
    input  wire logic                        ce,
    input  wire logic                        sckPin,
    input  wire logic                        csPin_n,
    input  wire logic                        siPin,
    output logic                             soOut,
    output logic                             soOe_n,
    output logic                             lsbMode,
    output logic [7:0]                       pageSelect,
    output logic [PAGE_W+ADDR_W-1:0]         accAddr,
    input  wire logic [IDX_W-1:0]            mapIndex,
    input  wire logic                        mapLast,
    input  wire logic                        mapDynamic,
    input  wire logic [NBYTES*BYTE_W-1:0]    rdWord,
    output logic                             wrStrobe,
    output logic [PAGE_W+ADDR_W-1:0]         wrAddr,
    output logic [NBYTES*BYTE_W-1:0]         wrWord,
    output logic [IDX_W:0]                   wrLen
);
    logic [2:0]                     syncBits;
    logic                           sckS;
    logic                           csS_n;
    logic                           siS;
    logic                           sckPrev_reg;
    logic                           csPrev_reg;
    logic                           sckRise;
    logic                           sckFall;
    logic                           csStart;
    logic                           active;
    psrp_phase_type                 phase_reg;
    logic [3:0]                     bitCnt_reg;
    logic [7:0]                     shiftIn_reg;
    logic [7:0]                     cmd_reg;
    logic [7:0]                     inByte;
    logic [7:0]                     shiftOut_reg;
    logic                           readPhase_reg;
    logic [7:0]                     page_reg;
    logic [NBYTES*BYTE_W-1:0]       stage_reg;
    logic [NBYTES*BYTE_W-1:0]       snap_reg;
    logic [7:0]                     rdByte;
    logic [PAGE_W+ADDR_W-1:0]       accAddr_reg;
    logic                           wrStrobe_reg;
    logic [PAGE_W+ADDR_W-1:0]       wrAddr_reg;
    logic [NBYTES*BYTE_W-1:0]       wrWord_reg;
    logic [IDX_W:0]                 wrLen_reg;
    logic                           lsb_reg;

    // pins cross into clk through two flops each; select travels active high so the
    // synchroniser's zero reset reads as deselected and no false select edge follows reset
    psrp_sync #(.W(3)) u_sync (
        .clk     (clk),
        .arst_n  (arst_n),
        .ce      (ce),
        .pinIn   ({sckPin, !csPin_n, siPin}),
        .syncOut (syncBits)
    );
    assign sckS  = syncBits[2];
    assign csS_n = !syncBits[1];
    assign siS   = syncBits[0];

    // edge detection on the synchronised pins
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            sckPrev_reg <= 1'b0;
            csPrev_reg  <= 1'b1;
        end else if (ce) begin
            sckPrev_reg <= sckS;
            csPrev_reg  <= csS_n;
        end
    end
    assign active  = !csS_n;
    assign csStart = csPrev_reg && !csS_n;
    assign sckRise = active && !csStart && sckS && !sckPrev_reg;
    assign sckFall = active && !csStart && !sckS && sckPrev_reg;
    assign inByte  = psrp_shift_in(shiftIn_reg, siS, lsb_reg);

    // bit order latched from clock level at select activation
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            lsb_reg <= 1'b0;
        end else if (ce && csStart) begin
            lsb_reg <= sckS;
        end
    end

    // phase and bit counter; deselect aborts a partial access
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            phase_reg  <= PH_IDLE;
            bitCnt_reg <= 4'h0;
        end else if (ce) begin
            if (!active || csStart) begin
                phase_reg  <= active ? PH_CMD : PH_IDLE;
                bitCnt_reg <= 4'h0;
            end else if (sckRise) begin
                bitCnt_reg <= bitCnt_reg + 4'h1;                 // wraps: next access follows at once
                case (phase_reg)
                    PH_CMD:  phase_reg <= (bitCnt_reg == CNT_CMD_DONE - 4'h1) ? PH_DATA : PH_CMD;
                    PH_DATA: phase_reg <= (bitCnt_reg == CNT_LAST_BIT) ? PH_CMD : PH_DATA;
                    default: phase_reg <= PH_CMD;
                endcase
            end
        end
    end

    // input shifter and command capture, sampled on rising clock
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            shiftIn_reg <= 8'h00;
            cmd_reg     <= 8'h00;
            accAddr_reg <= '0;
        end else if (ce && sckRise) begin
            shiftIn_reg <= inByte;
            if (phase_reg == PH_CMD && bitCnt_reg == CNT_CMD_DONE - 4'h1) begin
                cmd_reg <= inByte;
                // low addresses ignore the page, banked ones carry it
                if (inByte[ADDR_W-1:0] <= DIRECT_LAST) begin
                    accAddr_reg <= {{PAGE_W{1'b0}}, inByte[ADDR_W-1:0]};
                end else begin
                    accAddr_reg <= {page_reg[PAGE_W-1:0], inByte[ADDR_W-1:0]};
                end
            end
        end
    end

    // page_select lives here; it persists until rewritten
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            page_reg <= PAGE_SEL_RESET;
        end else if (ce && sckRise && phase_reg == PH_DATA && bitCnt_reg == CNT_LAST_BIT
                     && !cmd_reg[CMD_RD_BIT] && cmd_reg[ADDR_W-1:0] == PAGE_SEL_ADDR) begin
            page_reg <= inByte;
        end
    end

    // write staging: lower bytes wait, last byte commits the whole word
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            stage_reg    <= '0;
            wrStrobe_reg <= 1'b0;
            wrAddr_reg   <= '0;
            wrWord_reg   <= '0;
            wrLen_reg    <= '0;
        end else if (ce) begin
            wrStrobe_reg <= 1'b0;
            // a read's data byte never reaches this path
            if (sckRise && phase_reg == PH_DATA && bitCnt_reg == CNT_LAST_BIT
                && !cmd_reg[CMD_RD_BIT] && cmd_reg[ADDR_W-1:0] != PAGE_SEL_ADDR) begin
                if (mapLast) begin
                    wrWord_reg <= stage_reg;
                    wrWord_reg[mapIndex*BYTE_W +: BYTE_W] <= inByte;
                    wrAddr_reg   <= accAddr_reg - {{(PAGE_W+ADDR_W-IDX_W){1'b0}}, mapIndex};
                    wrLen_reg    <= {1'b0, mapIndex} + {{IDX_W{1'b0}}, 1'b1};
                    wrStrobe_reg <= 1'b1;
                end else begin
                    stage_reg[mapIndex*BYTE_W +: BYTE_W] <= inByte;
                end
            end
        end
    end

    // byte to present: page_select, snapshot, or live register
    always_comb begin
        rdByte = rdWord[mapIndex*BYTE_W +: BYTE_W];
        if (cmd_reg[ADDR_W-1:0] == PAGE_SEL_ADDR) begin
            rdByte = page_reg;
        end else if (mapDynamic) begin
            // the lowest byte comes live, its neighbours from the frozen copy
            rdByte = (mapIndex == '0) ? rdWord[BYTE_W-1:0] : snap_reg[mapIndex*BYTE_W +: BYTE_W];
        end
    end

    // output shifter: loads on the falling edge after the command byte
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            shiftOut_reg  <= 8'h00;
            readPhase_reg <= 1'b0;
            snap_reg      <= '0;
        end else if (ce) begin
            if (!active) begin
                readPhase_reg <= 1'b0;
            end else if (sckFall) begin
                if (phase_reg == PH_DATA && bitCnt_reg == CNT_CMD_DONE && cmd_reg[CMD_RD_BIT]) begin
                    shiftOut_reg  <= rdByte;
                    readPhase_reg <= 1'b1;                       // drive only on reads
                    if (mapDynamic && mapIndex == '0) begin
                        snap_reg <= rdWord;
                    end
                end else if (readPhase_reg && phase_reg == PH_DATA) begin
                    shiftOut_reg <= lsb_reg ? {1'b0, shiftOut_reg[7:1]} : {shiftOut_reg[6:0], 1'b0};
                end else begin
                    readPhase_reg <= 1'b0;
                end
            end
        end
    end

    // the bit on the line is the head of the shifter in the chosen order
    assign soOut      = lsb_reg ? shiftOut_reg[0] : shiftOut_reg[7];
    assign soOe_n     = !(readPhase_reg && active);
    assign lsbMode    = lsb_reg;
    assign pageSelect = page_reg;
    assign accAddr    = accAddr_reg;
    assign wrStrobe   = wrStrobe_reg;
    assign wrAddr     = wrAddr_reg;
    assign wrWord     = wrWord_reg;
    assign wrLen      = wrLen_reg;
endmodule : psrp_port

// [psrp_port_assertions.sv]
// assertion checker for the paged serial register port
`timescale 1ns/1ps
module psrp_port_assertions
    import psrp_pkg::*;
#(
    parameter int NBYTES = MAX_BYTES
) (
    input wire logic                     clk,
    input wire logic                     arst_n,
    input wire logic                     csPin_n,
    input wire logic                     soOe_n,
    input wire logic                     lsbMode,
    input wire logic [7:0]               pageSelect,
    input wire logic [PAGE_W+ADDR_W-1:0] accAddr,
    input wire logic                     wrStrobe,
    input wire logic [PAGE_W+ADDR_W-1:0] wrAddr,
    input wire logic [NBYTES*BYTE_W-1:0] wrWord,
    input wire logic [IDX_W:0]           wrLen
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!arst_n);
    // eight cycles covers the pin synchroniser and edge detect
    sequence s_idle; csPin_n [*8]; endsequence
    sequence s_busy; !csPin_n [*8]; endsequence
    property p_quiet; s_idle |-> soOe_n && !wrStrobe && $stable(pageSelect); endproperty
    a_quiet: assert property (p_quiet) else $error("port active while deselected");
    property p_oe_sel; $fell(soOe_n) |-> !csPin_n && !$past(csPin_n, 8); endproperty
    a_oe_sel: assert property (p_oe_sel) else $error("output driven without a command byte");
    property p_oe_len; $fell(soOe_n) |-> (!soOe_n) [*8]; endproperty
    a_oe_len: assert property (p_oe_len) else $error("read byte cut short");
    property p_order; s_busy |-> $stable(lsbMode); endproperty
    a_order: assert property (p_order) else $error("bit order changed mid transaction");
    property p_direct; accAddr[6:0] <= DIRECT_LAST |-> accAddr[ADDR_W+:PAGE_W] == 0; endproperty
    a_direct: assert property (p_direct) else $error("direct address carries a page");
    property p_bank; accAddr[6:0] > DIRECT_LAST |-> accAddr[ADDR_W+:PAGE_W] == pageSelect[PAGE_W-1:0]; endproperty
    a_bank: assert property (p_bank) else $error("banked address ignores the page");
    property p_pulse; wrStrobe |-> wrLen != 0 && wrLen <= NBYTES ##1 !wrStrobe; endproperty
    a_pulse: assert property (p_pulse) else $error("commit pulse wrong");
    property p_hold; !wrStrobe |-> $stable(wrWord) && $stable(wrAddr) && $stable(wrLen); endproperty
    a_hold: assert property (p_hold) else $error("commit outputs moved without a pulse");
endmodule : psrp_port_assertions

bind psrp_port psrp_port_assertions #(.NBYTES(NBYTES)) chk_u (.clk(clk), .arst_n(arst_n), .csPin_n(csPin_n),
    .soOe_n(soOe_n), .lsbMode(lsbMode), .pageSelect(pageSelect), .accAddr(accAddr), .wrStrobe(wrStrobe),
    .wrAddr(wrAddr), .wrWord(wrWord), .wrLen(wrLen));

// [psrp_host_model.sv]
// host serial master model driving the port's pins
`timescale 1ns/1ps
module psrp_host_model (
    input  wire logic clk,
    input  wire logic soOut,
    input  wire logic soOe_n,
    output logic      sck,
    output logic      selPin_n,
    output logic      si
);
    logic lastSo;
    logic soLine;
    initial begin
        sck = 1'b0;
        selPin_n = 1'b1;
        si = 1'b0;
        lastSo = 1'b0;
    end
    // no pull on the line, so a released output shows the inverse of its last bit
    always @(posedge clk) if (!soOe_n) lastSo <= soOut;
    assign soLine = soOe_n ? ~lastSo : soOut;
    // one link half period of four clocks, changes just after an edge
    task automatic half();
        repeat (4) @(posedge clk);
        #2;
    endtask : half
    // command byte then data byte; sel low leaves this device deselected
    task automatic access(input logic sel, input logic lsb, input logic [7:0] cmd, input logic [7:0] dat,
                          output logic [7:0] rd);
        int p;
        rd = 8'h00;
        sck = lsb; // idle level picks the bit order
        half();
        half();
        selPin_n = !sel;
        half();
        for (int i = 0; i < 16; i++) begin
            p = lsb ? i % 8 : 7 - i % 8;
            sck = 1'b0;
            si = (i < 8) ? cmd[p] : dat[p];
            half();
            if (i >= 8) rd[p] = soLine; // only meaningful on reads
            sck = 1'b1;
            half();
        end
        sck = lsb;
        si = ~si;
        half();
        selPin_n = 1'b1;
        half();
        half();
    endtask : access
endmodule : psrp_host_model

// [psrp_port_tb.sv]
// self-checking bench for the paged serial register port
`timescale 1ns/1ps
module psrp_port_tb
    import psrp_pkg::*;
;
    logic clk, arst_n, ce, sckPin, csPin_n, siPin, soOut, soOe_n, lsbMode, mapLast, mapDynamic, wrStrobe, multi;
    logic [7:0] pageSelect, rd;
    logic [10:0] accAddr, wrAddr, stbAddr;
    logic [IDX_W-1:0] mapIndex;
    logic [31:0] rdWord, wrWord, dynVal, stbWord;
    logic [2:0] wrLen, stbLen;
    int stbCnt = 0;
    int error_cnt = 0;
    int checks = 0;
    psrp_port dut_u (.clk(clk), .arst_n(arst_n), .ce(ce), .sckPin(sckPin), .csPin_n(csPin_n), .siPin(siPin),
        .soOut(soOut), .soOe_n(soOe_n), .lsbMode(lsbMode), .pageSelect(pageSelect), .accAddr(accAddr),
        .mapIndex(mapIndex), .mapLast(mapLast), .mapDynamic(mapDynamic), .rdWord(rdWord), .wrStrobe(wrStrobe),
        .wrAddr(wrAddr), .wrWord(wrWord), .wrLen(wrLen));
    psrp_host_model host_u (.clk(clk), .soOut(soOut), .soOe_n(soOe_n), .sck(sckPin), .selPin_n(csPin_n), .si(siPin));
    // map stand-in: 0x10-0x13 staged word, 0x20-0x23 dynamic word, others echo their address
    assign mapDynamic = accAddr[6:2] == 5'h08;
    assign multi = mapDynamic || accAddr[6:2] == 5'h04;
    assign mapIndex = multi ? accAddr[1:0] : 2'h0;
    assign mapLast = !multi || mapIndex == 2'h3;
    assign rdWord = mapDynamic ? dynVal : {21'h0, accAddr};
    // keep the last commit so later checks see it
    always @(posedge clk) if (wrStrobe === 1'b1) begin
        stbCnt++;
        stbWord = wrWord;
        stbAddr = wrAddr;
        stbLen = wrLen;
    end
    task automatic chk(input string name, input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("ERROR %s expected %h seen %h", name, exp, got);
        end
    endtask : chk
    task automatic results();
        $display("checks %0d errors %0d", checks, error_cnt);
        if (error_cnt == 0 && checks > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask : results
    task automatic t_reset();
        chk("pageSelect", pageSelect, PAGE_SEL_RESET);
        chk("soOe_n", soOe_n, 1'b1);
        chk("wrStrobe", wrStrobe, 1'b0);
    endtask : t_reset
    // page write msb first, read back lsb first with junk on the input line
    task automatic t_page();
        host_u.access(1'b1, 1'b0, {1'b0, PAGE_SEL_ADDR}, 8'h02, rd);
        chk("lsbMode", lsbMode, 1'b0);
        chk("pageSelect", pageSelect, 8'h02);
        host_u.access(1'b1, 1'b1, {1'b1, PAGE_SEL_ADDR}, 8'ha5, rd);
        chk("lsbMode", lsbMode, 1'b1);
        chk("page read", rd, 8'h02);
        chk("pageSelect", pageSelect, 8'h02);
        chk("soOe_n", soOe_n, 1'b1);
        chk("strobes", stbCnt, 0);
    endtask : t_page
    // banked 0x70 on page 2, then direct 0x30 without a page
    task automatic t_bank();
        host_u.access(1'b1, 1'b0, 8'hf0, 8'h00, rd);
        chk("accAddr", accAddr, {4'h2, 7'h70});
        chk("banked read", rd, 8'h70);
        host_u.access(1'b1, 1'b1, 8'hb0, 8'h00, rd);
        chk("accAddr", accAddr, 11'h030);
        chk("direct read", rd, 8'h30);
        chk("pageSelect", pageSelect, 8'h02);
    endtask : t_bank
    // four-byte write, lowest byte first, committed only by the last
    task automatic t_multi_wr();
        for (int i = 0; i < 3; i++) begin
            host_u.access(1'b1, 1'b1, 8'h10 + 8'(i), 8'h11 * 8'(i + 1), rd);
            chk("strobes", stbCnt, 0);
        end
        host_u.access(1'b1, 1'b1, 8'h13, 8'h44, rd);
        chk("strobes", stbCnt, 1);
        chk("wrWord", stbWord, 32'h44332211);
        chk("wrAddr", stbAddr, 11'h010);
        chk("wrLen", stbLen, 3'h4);
    endtask : t_multi_wr
    // traffic for another device, or while the port is frozen, must leave this one untouched
    task automatic t_desel();
        host_u.access(1'b0, 1'b0, {1'b0, PAGE_SEL_ADDR}, 8'h09, rd);
        chk("pageSelect", pageSelect, 8'h02);
        chk("strobes", stbCnt, 1);
        ce = 1'b0;
        host_u.access(1'b1, 1'b0, {1'b0, PAGE_SEL_ADDR}, 8'h0b, rd);
        ce = 1'b1;
        chk("pageSelect", pageSelect, 8'h02);
        chk("strobes", stbCnt, 1);
    endtask : t_desel
    // live value moves after the lowest byte; later bytes come from the snapshot
    task automatic t_dyn_rd();
        dynVal = 32'h44332211;
        host_u.access(1'b1, 1'b0, 8'ha0, 8'h00, rd); // lowest byte first
        chk("dyn byte", rd, 8'h11);
        dynVal = 32'hddccbbaa;
        for (int i = 1; i < 4; i++) begin
            host_u.access(1'b1, 1'b0, 8'ha0 + 8'(i), 8'h00, rd); // most significant byte last
            chk("dyn byte", rd, 8'h11 * 8'(i + 1));
        end
    endtask : t_dyn_rd
    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end
    // a hang ends the run as a failure
    initial begin
        repeat (20000) @(posedge clk);
        error_cnt++;
        results();
    end
    initial begin
        arst_n = 1'b0;
        ce = 1'b1;
        dynVal = 32'h0;
        repeat (3) @(posedge clk);
        #2 arst_n = 1'b1;
        t_reset();
        t_page();
        t_bank();
        t_multi_wr();
        t_desel();
        t_dyn_rd();
        results();
    end
endmodule : psrp_port_tb
